// *** ccr_cfg.svh ***
// Purpose: constants of the clock generator control register bank
// Assumes: registers reached over the two-wire serial port only
// Notes: offsets are byte indices on the serial link
//
// How it works
// - start, write address, device acknowledges
// - index byte acknowledged and kept as start
// - repeated start, read address, device acknowledges
// - send byte count, then bytes from index onward
// - host not-acknowledge ends read, line released
// - byte0 bit7 enables processor/serial-ref PLL
// - byte0 bit6 enables dot clock PLL
// - byte0 bit5 enables LCD PLL
// - byte0 bit3 divider cleared when bit7 cleared
// - byte0 bit2 divider cleared when bit7 cleared
// - byte0 bit1 divider cleared when bit5 cleared
// - byte0 bit0 divider cleared when bit6 cleared
// - byte1 bit7 fixed down spread for PLL
// - byte1 bit6 enables LCD PLL spread
// - byte1 bits5-3 select LCD spread, reset 000
// - codes 0-3 down spread, 4-7 centre spread
// - byte2 bits7-5 processor clock buffer enables
// - byte2 bits4-2 serial-ref clock buffer enables
// - byte2 bit1 dot clock buffer enable
// - byte2 bit0 LCD clock buffer enable
// - block write: index, count, data, all acknowledged
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// ----------------------------------------------------------------
// serial addresses and map
// ----------------------------------------------------------------
`define CCR_ADDR_WR 8'hD2
`define CCR_ADDR_RD 8'hD3
`define CCR_OFS_PLL_DIV 8'h00
`define CCR_OFS_SPREAD 8'h01
`define CCR_OFS_BUF 8'h02
`define CCR_BYTE_COUNT 8'h03

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define CCR_RST_PLL_DIV 8'hEF
`define CCR_RST_SPREAD 8'hC0
`define CCR_RST_BUF 8'hFF
`define CCR_MASK_PLL_DIV 8'hEF
`define CCR_MASK_SPREAD 8'hF8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCR_B_CPU_SRC_PLL 7
`define CCR_B_DOT_PLL 6
`define CCR_B_LCD_PLL 5
`define CCR_B_PROC_DIV 3
`define CCR_B_SREF_DIV 2
`define CCR_B_LCD_DIV 1
`define CCR_B_DOT_DIV 0
`define CCR_B_CPU_SRC_SS 7
`define CCR_B_LCD_SS 6
`define CCR_B_SEL_HI 5
`define CCR_B_SEL_LO 3

`endif

// *** ccr_pkg.sv ***
// Purpose: types of the clock generator control register bank
// Assumes: constants come from ccr_cfg.svh
// Notes: none
`default_nettype none
package ccr_pkg;

  typedef enum logic [2:0] {
    CCR_ST_IDLE,
    CCR_ST_RX,
    CCR_ST_RX_ACK,
    CCR_ST_TX,
    CCR_ST_TX_ACK,
    CCR_ST_TX_NEXT
  } ccr_state_t;

  typedef enum logic [1:0] {
    CCR_PH_ADDR,
    CCR_PH_INDEX,
    CCR_PH_COUNT,
    CCR_PH_DATA
  } ccr_phase_t;

  // lcd spread: low half down spread, high half centre spread
  typedef enum logic [2:0] {
    CCR_SS_DN_0P5,
    CCR_SS_DN_1P0,
    CCR_SS_DN_2P0,
    CCR_SS_DN_2P5,
    CCR_SS_CT_0P25,
    CCR_SS_CT_0P5,
    CCR_SS_CT_1P0,
    CCR_SS_CT_1P25
  } ccr_spread_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    ccr_state_t st;
    ccr_phase_t ph;
    logic rd;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] idx;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r2;
    logic drv;
    logic [7:0] ck_t;
    logic [7:0] ck_c;
  } ccr_regs_t;

endpackage : ccr_pkg
`default_nettype wire

// *** ccr_regs.sv ***
// Purpose: serial slave and control registers of the clock generator
// Assumes: scl and sda pins are asynchronous to sys_clk_in
// Notes: raw clocks come from on-chip logic on sys_clk_in
`timescale 1ns/100ps
`default_nettype none
`include "ccr_cfg.svh"
module ccr_regs
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [7:0] raw_clk_in,
  output logic [7:0] clk_true_out,
  output logic [7:0] clk_comp_out,
  output logic cpu_src_pll_on_out,
  output logic dot_pll_on_out,
  output logic lcd_pll_on_out,
  output logic proc_divider_on_out,
  output logic serial_ref_divider_on_out,
  output logic lcd_divider_on_out,
  output logic dot_divider_on_out,
  output logic cpu_src_spread_on_out,
  output logic lcd_spread_on_out,
  output ccr_pkg::ccr_spread_t lcd_spread_select_out
);
  import ccr_pkg::*;

  ccr_regs_t s;
  ccr_regs_t next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rdata;
  logic [7:0] next_idx;
  logic [7:0] w0;
  logic [7:0] w1;

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------
  // edges from stages two and three, never from the first
  assign scl_rise = s.scl_s & ~s.scl_p;
  assign scl_fall = ~s.scl_s & s.scl_p;
  // sda moves only while scl is low, except start and stop
  assign start_seen = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
  assign stop_seen = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
  assign next_idx = s.idx + 8'h01;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    case (s.idx)
      `CCR_OFS_PLL_DIV: rdata = s.r0;
      `CCR_OFS_SPREAD: rdata = s.r1;
      `CCR_OFS_BUF: rdata = s.r2;
      default: rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // byte 0 write with divider interlocks
  // ----------------------------------------------------------------
  always_comb
  begin
    w0 = s.sh & `CCR_MASK_PLL_DIV;
    if (!w0[`CCR_B_CPU_SRC_PLL])
    begin
      w0[`CCR_B_PROC_DIV] = 1'b0;
      w0[`CCR_B_SREF_DIV] = 1'b0;
    end
    if (!w0[`CCR_B_LCD_PLL])
    begin
      w0[`CCR_B_LCD_DIV] = 1'b0;
    end
    if (!w0[`CCR_B_DOT_PLL])
    begin
      w0[`CCR_B_DOT_DIV] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // byte 1 write, reserved bits dropped
  // ----------------------------------------------------------------
  always_comb
  begin
    w1 = s.sh & `CCR_MASK_SPREAD;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // two stages before any use, a third for edges
    next_s.scl_m = scl_in;
    next_s.scl_s = s.scl_m;
    next_s.scl_p = s.scl_s;
    next_s.sda_m = sda_in;
    next_s.sda_s = s.sda_m;
    next_s.sda_p = s.sda_s;
    // disabled buffers park both legs low
    next_s.ck_t = raw_clk_in & s.r2;
    next_s.ck_c = ~raw_clk_in & s.r2;
    if (stop_seen)
    begin
      next_s.st = CCR_ST_IDLE;
      next_s.drv = 1'b0;
    end
    else if (start_seen)
    begin
      // start or repeated start: new address byte
      next_s.st = CCR_ST_RX;
      next_s.ph = CCR_PH_ADDR;
      next_s.cnt = 4'h0;
      next_s.drv = 1'b0;
    end
    else
    begin
      case (s.st)
        CCR_ST_IDLE:
        begin
          next_s.drv = 1'b0;
        end
        CCR_ST_RX:
        begin
          // shift on rise, hold at eight until the fall
          if (scl_rise && s.cnt != 4'h8)
          begin
            next_s.sh = {s.sh[6:0], s.sda_s};
            next_s.cnt = s.cnt + 4'h1;
          end
          else if (scl_fall && s.cnt == 4'h8)
          begin
            next_s.st = CCR_ST_RX_ACK;
            next_s.drv = 1'b1;
            case (s.ph)
              CCR_PH_ADDR:
              begin
                // other addresses: no ack, wait for a start
                if (s.sh == `CCR_ADDR_WR)
                begin
                  next_s.rd = 1'b0;
                  next_s.ph = CCR_PH_INDEX;
                end
                else if (s.sh == `CCR_ADDR_RD)
                begin
                  next_s.rd = 1'b1;
                end
                else
                begin
                  next_s.st = CCR_ST_IDLE;
                  next_s.drv = 1'b0;
                end
              end
              CCR_PH_INDEX:
              begin
                next_s.idx = s.sh;
                next_s.ph = CCR_PH_COUNT;
              end
              CCR_PH_COUNT:
              begin
                next_s.ph = CCR_PH_DATA;
              end
              default:
              begin
                case (s.idx)
                  `CCR_OFS_PLL_DIV: next_s.r0 = w0;
                  `CCR_OFS_SPREAD: next_s.r1 = w1;
                  `CCR_OFS_BUF: next_s.r2 = s.sh;
                  // past byte 2: acknowledged, dropped
                  default: next_s.r2 = s.r2;
                endcase
                next_s.idx = next_idx;
              end
            endcase
          end
        end
        CCR_ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            next_s.cnt = 4'h0;
            if (s.rd)
            begin
              // count byte first, index untouched
              next_s.sh = `CCR_BYTE_COUNT;
              next_s.drv = ~next_s.sh[7];
              next_s.st = CCR_ST_TX;
            end
            else
            begin
              next_s.drv = 1'b0;
              next_s.st = CCR_ST_RX;
            end
          end
        end
        CCR_ST_TX:
        begin
          if (scl_fall)
          begin
            if (s.cnt == 4'h7)
            begin
              next_s.drv = 1'b0;
              next_s.st = CCR_ST_TX_ACK;
            end
            else
            begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.drv = ~s.sh[6];
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        end
        CCR_ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            // line already released for the host's answer
            if (s.sda_s)
            begin
              next_s.st = CCR_ST_IDLE;
            end
            else
            begin
              next_s.st = CCR_ST_TX_NEXT;
            end
          end
        end
        CCR_ST_TX_NEXT:
        begin
          if (scl_fall)
          begin
            // next byte only after the ack clock falls
            next_s.sh = rdata;
            next_s.drv = ~rdata[7];
            next_s.idx = next_idx;
            next_s.cnt = 4'h0;
            next_s.st = CCR_ST_TX;
          end
        end
        default:
        begin
          next_s.st = CCR_ST_IDLE;
          next_s.drv = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s <= '0;
      // line copies idle high: no false start after reset
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_p <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_p <= 1'b1;
      s.st <= CCR_ST_IDLE;
      s.ph <= CCR_PH_ADDR;
      s.r0 <= `CCR_RST_PLL_DIV;
      s.r1 <= `CCR_RST_SPREAD;
      s.r2 <= `CCR_RST_BUF;
    end
    else if (clk_en_in)
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe_out = s.drv;
  assign clk_true_out = s.ck_t;
  assign clk_comp_out = s.ck_c;
  assign cpu_src_pll_on_out = s.r0[`CCR_B_CPU_SRC_PLL];
  assign dot_pll_on_out = s.r0[`CCR_B_DOT_PLL];
  assign lcd_pll_on_out = s.r0[`CCR_B_LCD_PLL];
  assign proc_divider_on_out = s.r0[`CCR_B_PROC_DIV];
  assign serial_ref_divider_on_out = s.r0[`CCR_B_SREF_DIV];
  assign lcd_divider_on_out = s.r0[`CCR_B_LCD_DIV];
  assign dot_divider_on_out = s.r0[`CCR_B_DOT_DIV];
  assign cpu_src_spread_on_out = s.r1[`CCR_B_CPU_SRC_SS];
  assign lcd_spread_on_out = s.r1[`CCR_B_LCD_SS];
  assign lcd_spread_select_out =
    ccr_spread_t'(s.r1[`CCR_B_SEL_HI:`CCR_B_SEL_LO]);

endmodule : ccr_regs
`default_nettype wire

// *** ccr_regs_assertions.sv ***
// Purpose: port checks on the control register bank
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every ccr_regs instance
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_chk
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [7:0] raw_clk_in,
  input wire logic [7:0] clk_true_out,
  input wire logic [7:0] clk_comp_out,
  input wire logic cpu_src_pll_on_out,
  input wire logic dot_pll_on_out,
  input wire logic lcd_pll_on_out,
  input wire logic proc_divider_on_out,
  input wire logic serial_ref_divider_on_out,
  input wire logic lcd_divider_on_out,
  input wire logic dot_divider_on_out
);
  wire logic [6:0] ctrl = {cpu_src_pll_on_out, dot_pll_on_out,
    lcd_pll_on_out, proc_divider_on_out, serial_ref_divider_on_out,
    lcd_divider_on_out, dot_divider_on_out};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_scl_low;
    !scl_in && !$past(scl_in);
  endsequence
  property p_proc_div;
    proc_divider_on_out |-> cpu_src_pll_on_out;
  endproperty
  property p_sref_div;
    serial_ref_divider_on_out |-> cpu_src_pll_on_out;
  endproperty
  property p_lcd_div;
    lcd_divider_on_out |-> lcd_pll_on_out;
  endproperty
  property p_dot_div;
    dot_divider_on_out |-> dot_pll_on_out;
  endproperty
  property p_true;
    $past(clk_en_in) |-> (clk_true_out & ~$past(raw_clk_in)) == 8'h00;
  endproperty
  property p_comp;
    $past(clk_en_in) |-> (clk_comp_out & $past(raw_clk_in)) == 8'h00;
  endproperty
  property p_oe_hold;
    $rose(sda_oe_out) |-> sda_oe_out [*8];
  endproperty
  property p_oe_chg;
    $changed(sda_oe_out) |-> s_scl_low;
  endproperty
  property p_ctrl_chg;
    $changed(ctrl) |-> s_scl_low;
  endproperty
  a_proc_div:
    assert property (p_proc_div) else $error("proc divider without pll");
  a_sref_div:
    assert property (p_sref_div) else $error("sref divider without pll");
  a_lcd_div:
    assert property (p_lcd_div) else $error("lcd divider without pll");
  a_dot_div:
    assert property (p_dot_div) else $error("dot divider without pll");
  a_true:
    assert property (p_true) else $error("true output not from raw");
  a_comp:
    assert property (p_comp) else $error("comp output not from raw");
  a_oe_hold:
    assert property (p_oe_hold) else $error("sda drive too short");
  a_oe_chg:
    assert property (p_oe_chg) else $error("sda changed with scl high");
  a_ctrl_chg:
    assert property (p_ctrl_chg) else $error("control changed scl high");
endmodule : ccr_regs_chk
bind ccr_regs ccr_regs_chk u_chk (.sys_clk_in, .rst_b_in, .clk_en_in,
  .scl_in, .sda_out, .sda_oe_out, .raw_clk_in, .clk_true_out,
  .clk_comp_out, .cpu_src_pll_on_out, .dot_pll_on_out, .lcd_pll_on_out,
  .proc_divider_on_out, .serial_ref_divider_on_out, .lcd_divider_on_out,
  .dot_divider_on_out);
`default_nettype wire

// *** ccr_host.sv ***
// Purpose: two-wire serial host model
// Assumes: open-drain data line with pull-up
// Notes: scl quarter period of four system clocks
`timescale 1ns/100ps
`default_nettype none
module ccr_host
(
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic qp;
    repeat (4) @(posedge sys_clk_in);
    #1;
  endtask : qp
  task automatic send_start;
    qp();
    sda_oe_out = 1'b0;
    qp();
    scl_out = 1'b1;
    qp();
    sda_oe_out = 1'b1;
    qp();
    scl_out = 1'b0;
  endtask : send_start
  task automatic send_stop;
    qp();
    sda_oe_out = 1'b1;
    qp();
    scl_out = 1'b1;
    qp();
    sda_oe_out = 1'b0;
    qp();
  endtask : send_stop
  task automatic bit_io(input logic b, output logic r);
    qp();
    sda_oe_out = !b;
    qp();
    scl_out = 1'b1;
    qp();
    r = sda_in;
    qp();
    scl_out = 1'b0;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : ccr_host
`default_nettype wire

// *** ccr_regs_bench.sv ***
// Purpose: self-checking bench of the control register bank
// Assumes: host model on the serial pins
// Notes: raw clocks count up to vary every bit
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_bench;
  import ccr_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] raw = 8'h00;
  wire logic host_oe, scl, dut_sda, dut_oe, sda, cpu_ss, lcd_ss;
  wire logic [7:0] t_out, c_out;
  wire logic [6:0] ctrl;
  ccr_spread_t sel;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] q [4];
  logic [7:0] w0 [5] = '{8'h6F, 8'h9F, 8'hDF, 8'h0F, 8'hFF};
  logic [7:0] e0 [5] = '{8'h63, 8'h8C, 8'hCD, 8'h00, 8'hEF};
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) raw <= #1 raw + 8'h01;
  assign sda = !host_oe && !(dut_oe && !dut_sda);
  ccr_host host (.sys_clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(host_oe));
  ccr_regs dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .clk_en_in(clk_en), .scl_in(scl), .sda_in(sda), .sda_out(dut_sda),
    .sda_oe_out(dut_oe), .raw_clk_in(raw), .clk_true_out(t_out),
    .clk_comp_out(c_out), .cpu_src_pll_on_out(ctrl[6]),
    .dot_pll_on_out(ctrl[5]), .lcd_pll_on_out(ctrl[4]),
    .proc_divider_on_out(ctrl[3]), .serial_ref_divider_on_out(ctrl[2]),
    .lcd_divider_on_out(ctrl[1]), .dot_divider_on_out(ctrl[0]),
    .cpu_src_spread_on_out(cpu_ss), .lcd_spread_on_out(lcd_ss),
    .lcd_spread_select_out(sel));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [7:0] d, input logic [7:0] ack);
    logic a;
    host.wr_byte(d, a);
    chk({7'h00, a}, ack);
  endtask : put
  task automatic wr(input logic [7:0] idx, input int n);
    host.send_start();
    put(8'hD2, 8'h01);
    put(idx, 8'h01);
    put(n[7:0], 8'h01);
    for (int i = 0; i < n; i++)
      put(q[i], 8'h01);
    host.send_stop();
  endtask : wr
  task automatic rd(input logic [7:0] idx, input int n);
    logic [7:0] d;
    host.send_start();
    put(8'hD2, 8'h01);
    put(idx, 8'h01);
    host.send_start();
    put(8'hD3, 8'h01);
    host.rd_byte(1'b0, d);
    chk(d, 8'h03);
    for (int i = 0; i < n; i++)
    begin
      host.rd_byte(i == n - 1, d);
      chk(d, q[i]);
    end
    host.send_stop();
    chk({7'h00, dut_oe}, 8'h00);
  endtask : rd
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (100000) @(posedge sys_clk_in);
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    #1 rst_b_in = 1'b1;
    chk({1'b0, ctrl}, 8'h7F);
    chk({cpu_ss, lcd_ss, sel, 3'b000}, 8'hC0);
    q = '{8'hEF, 8'hC0, 8'hFF, 8'h00};
    rd(8'h00, 4);
    for (int i = 0; i < 5; i++)
    begin
      q[0] = w0[i];
      wr(8'h00, 1);
      q[0] = e0[i];
      rd(8'h00, 1);
      chk({1'b0, ctrl}, {1'b0, e0[i][7:5], e0[i][3:0]});
    end
    for (int i = 0; i < 8; i++)
    begin
      q[0] = {i[0], !i[0], i[2:0], 3'b111};
      wr(8'h01, 1);
      q[0] = q[0] & 8'hF8;
      rd(8'h01, 1);
      chk({cpu_ss, lcd_ss, sel, 3'b000}, q[0]);
    end
    q = '{8'h5A, 8'hA5, 8'h77, 8'h00};
    wr(8'h01, 3);
    q = '{8'h58, 8'hA5, 8'h00, 8'h00};
    rd(8'h01, 3);
    repeat (3)
    begin
      @(posedge sys_clk_in);
      #5;
      chk(t_out, (raw - 8'h01) & 8'hA5);
      chk(c_out, ~(raw - 8'h01) & 8'hA5);
    end
    // clock enable low: outputs freeze
    @(posedge sys_clk_in);
    #1 clk_en = 1'b0;
    q[1] = t_out;
    repeat (3) @(posedge sys_clk_in);
    #5 chk(t_out, q[1]);
    // mid-run reset restores every default
    @(posedge sys_clk_in);
    #1 clk_en = 1'b1;
    rst_b_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1 rst_b_in = 1'b1;
    chk({1'b0, ctrl}, 8'h7F);
    chk({cpu_ss, lcd_ss, sel, 3'b000}, 8'hC0);
    chk(t_out, 8'h00);
    @(posedge sys_clk_in);
    #5;
    chk(t_out, raw - 8'h01);
    chk(c_out, ~(raw - 8'h01));
    q = '{8'hEF, 8'hC0, 8'hFF, 8'h00};
    rd(8'h00, 3);
    host.send_start();
    put(8'hA0, 8'h00);
    host.send_stop();
    end_sim();
  end
endmodule : ccr_regs_bench
`default_nettype wire
